// ---- inc/flash_host_defs.svh ----
// Purpose: Constants of the flash host controller
// Assumes: 100 MHz clock, 10 ns period
// Notes: Times in ns
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

`define FH_CLK_NS 10
// Register byte offsets
`define FH_OFS_CTRL 8'h00
`define FH_OFS_ADDR 8'h04
`define FH_OFS_WDATA 8'h08
`define FH_OFS_STATUS 8'h0c
`define FH_OFS_RDATA 8'h10
// CTRL fields
`define FH_CTRL_OP_LSB 0
`define FH_CTRL_GO_BIT 4
`define FH_CTRL_ACCEL_BIT 8
// STATUS fields
`define FH_ST_BUSY_BIT 0
`define FH_ST_RDY_BIT 1
`define FH_ST_FAIL_BIT 2
`define FH_ST_SECT_LSB 8
`define FH_ST_GROUP_LSB 16
// Failure flag bit of the data bus
`define FH_FAIL_BIT 5
// Reset command byte
`define FH_CMD_RESET 8'hf0
// Reset values
`define FH_RST_ADDR 22'h000000
`define FH_RST_WDATA 8'h00
// Timing (least times, rounded up)
`define FH_T_SETUP_NS 10
`define FH_T_ACC_NS 90
`define FH_T_WP_NS 40
`define FH_T_PROT_NS 1000
`define FH_T_REC_NS 20
`define FH_T_RP_NS 500
`define FH_CYC(ns) (((ns) + `FH_CLK_NS - 1) / `FH_CLK_NS)

`endif

// ---- inc/flash_host_pkg.sv ----
// Purpose: Types shared by the flash host controller
// Assumes: Nothing
// Notes: Constants live in flash_host_defs.svh
package flash_host_pkg;

    typedef enum logic [2:0] {
        OP_READ = 3'b000,
        OP_WRITE = 3'b001,
        OP_HW_RESET = 3'b010,
        OP_RESET_CMD = 3'b011,
        OP_PROTECT = 3'b100,
        OP_UNPROTECT = 3'b101,
        OP_LOCK_VERIFY = 3'b110,
        OP_ID_READ = 3'b111
    } op_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_RECOVER = 3'b011,
        ST_RESET = 3'b100
    } st_e;

    typedef struct packed {
        logic [21:0] address;
        logic [7:0] data_out;
        logic data_oe;
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic reset_n;
        logic reset_hv;
        logic a9_hv;
    } flash_pins_s;

endpackage

// ---- rtl/flash_host_ctrl.sv ----
// Purpose: Pin-level host controller of a 4M x 8 parallel flash
// Assumes: Flash inputs synchronous to clk
// Notes: Software sequences flash commands
//
// Summary of operation
// RULE_01: 64 sectors of 64KB; sector index is address bits 21..16.
// RULE_02: Eighteen groups: 0, 1-3, then fours, 60-62, 63.
// RULE_03: Flash refuses program or erase in a protected group.
// RULE_04: Protect: reset hv, CS WE low, OE high, A6 0 A1 1 A0 0; A6 1 unprotects.
// RULE_05: Reset pin low: flash to read mode, data bus floats.
// RULE_06: CS OE low, WE high: addressed byte after access time.
// RULE_07: CS or OE high leaves flash outputs tri-stated.
// RULE_08: Command cycles hold WE and CS low with OE high.
// RULE_09: Address latched on later falling edge of CS or WE.
// RULE_10: Data latched on earlier rising edge of CS or WE.
// RULE_11: Host issues only defined command sequences.
// RULE_12: Read-array mode after power-up or any reset.
// RULE_13: Read-array mode once program or erase completes.
// RULE_14: Erase suspend halts erase within latency, enters read-array.
// RULE_15: During suspend, reads of the erasing sector return status.
// RULE_16: Program in erase suspend allowed; other sectors stay readable.
// RULE_17: On failure data bit 5 rises; host must send reset command.
// RULE_18: Auto-select or query mode blocks array reads until reset command.
// RULE_19: Acceleration input at high voltage speeds programming.
// RULE_20: High voltage on acceleration input unprotects every sector.
// RULE_21: Reset pin at high voltage lifts group protection.
// RULE_22: Lock check with A9 high voltage returns 00h unprotected, 01h protected.
// RULE_23: A9 high voltage, A6 A1 low gives maker code, A0 high device code.
// RULE_24: Hard reset during busy keeps ready/busy low until read mode.
// RULE_25: Flash ignores reset command while program or erase runs.
// RULE_26: Reset command F0 returns flash to read-array mode.
// RULE_27: High-voltage levels are qualifier signals, not logic high.
// RULE_28: Flash drives ready/busy to show program or erase progress.
`timescale 1ns/1ps
`include "flash_host_defs.svh"

module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter logic [7:0] SETUP_CYC = 8'(`FH_CYC(`FH_T_SETUP_NS)),
    parameter logic [7:0] ACC_CYC = 8'(`FH_CYC(`FH_T_ACC_NS)),
    parameter logic [7:0] WP_CYC = 8'(`FH_CYC(`FH_T_WP_NS)),
    parameter logic [7:0] PROT_CYC = 8'(`FH_CYC(`FH_T_PROT_NS)),
    parameter logic [7:0] REC_CYC = 8'(`FH_CYC(`FH_T_REC_NS)),
    parameter logic [7:0] RP_CYC = 8'(`FH_CYC(`FH_T_RP_NS))
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [21:0] address_bus,
    output logic [7:0] data_bus_out,
    output logic data_bus_oe,
    input wire logic [7:0] data_bus_in,
    output logic chip_sel_n,
    output logic write_strobe_n,
    output logic output_strobe_n,
    output logic hard_reset_n,
    output logic hard_reset_hv,
    output logic a9_hv,
    output logic accel_program_input,
    input wire logic ready_busy_n
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] sector_of(input logic [21:0] a);
        return a[21:16]; // RULE_01
    endfunction

    function automatic logic [4:0] group_of(input logic [21:0] a);
        logic [5:0] s;
        s = a[21:16];
        if (s == 6'h00) return 5'h00; // RULE_02
        else if (s == 6'h3f) return 5'h11;
        else if (s >= 6'h3c) return 5'h10;
        else if (s <= 6'h03) return 5'h01;
        else return 5'(s[5:2]) + 5'h01;
    endfunction

    // Low address bits that pick protect, verify and id patterns
    function automatic logic [21:0] pin_addr(input op_e op, input logic [21:0] a);
        logic [21:0] r;
        r = a;
        case (op)
            OP_PROTECT, OP_LOCK_VERIFY, OP_UNPROTECT: begin
                r[6] = (op == OP_UNPROTECT); // RULE_04
                r[1] = 1'b1;
                r[0] = 1'b0;
            end
            OP_ID_READ: begin
                r[6] = 1'b0;
                r[1] = 1'b0;
            end
            default: r = a;
        endcase
        return r;
    endfunction

    function automatic logic is_write_op(input op_e op);
        return (op == OP_WRITE) || (op == OP_RESET_CMD) || (op == OP_PROTECT)
            || (op == OP_UNPROTECT);
    endfunction

    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [21:0] addr_q, addr_d;
    logic [7:0] wdat_q, wdat_d;
    logic [2:0] op_q, op_d;
    logic accel_q, accel_d;
    logic start_op;
    logic [7:0] rd_byte_q, rd_byte_d;
    st_e st_q, st_d;

    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        op_d = op_q;
        accel_d = accel_q;
        start_op = 1'b0;
        if (s_axi_awvalid && awready_q) begin
            aw_got_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_got_d = 1'b1;
            w_data_d = s_axi_wdata;
        end
        if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
        if (aw_got_q && w_got_q && !bvalid_q) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = 2'b00;
            case (aw_addr_q[7:2])
                `FH_OFS_CTRL >> 2: begin
                    if (w_data_q[`FH_CTRL_ACCEL_BIT] || w_data_q[`FH_CTRL_GO_BIT])
                        accel_d = w_data_q[`FH_CTRL_ACCEL_BIT];
                    // A start while a cycle is running is dropped
                    if (w_data_q[`FH_CTRL_GO_BIT] && st_q == ST_IDLE) begin
                        op_d = w_data_q[`FH_CTRL_OP_LSB +: 3];
                        start_op = 1'b1;
                    end
                end
                `FH_OFS_ADDR >> 2: addr_d = w_data_q[21:0];
                `FH_OFS_WDATA >> 2: wdat_d = w_data_q[7:0];
                `FH_OFS_STATUS >> 2, `FH_OFS_RDATA >> 2: bresp_d = 2'b00;
                default: bresp_d = 2'b10;
            endcase
        end
        if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = 2'b00;
            rdata_d = 32'h00000000;
            case (s_axi_araddr[7:2])
                `FH_OFS_CTRL >> 2: begin
                    rdata_d[`FH_CTRL_OP_LSB +: 3] = op_q;
                    rdata_d[`FH_CTRL_ACCEL_BIT] = accel_q;
                end
                `FH_OFS_ADDR >> 2: rdata_d[21:0] = addr_q;
                `FH_OFS_WDATA >> 2: rdata_d[7:0] = wdat_q;
                `FH_OFS_STATUS >> 2: begin
                    rdata_d[`FH_ST_BUSY_BIT] = (st_q != ST_IDLE);
                    rdata_d[`FH_ST_RDY_BIT] = ready_busy_n;
                    rdata_d[`FH_ST_FAIL_BIT] = rd_byte_q[`FH_FAIL_BIT]; // RULE_17
                    rdata_d[`FH_ST_SECT_LSB +: 6] = sector_of(addr_q); // RULE_01
                    rdata_d[`FH_ST_GROUP_LSB +: 5] = group_of(addr_q); // RULE_02
                end
                `FH_OFS_RDATA >> 2: rdata_d[7:0] = rd_byte_q;
                default: rresp_d = 2'b10;
            endcase
        end
        awready_d = !aw_got_d && !bvalid_d;
        wready_d = !w_got_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'b00;
            rdata_q <= 32'h00000000;
            addr_q <= `FH_RST_ADDR;
            wdat_q <= `FH_RST_WDATA;
            op_q <= 3'h0;
            accel_q <= 1'b0;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            op_q <= op_d;
            accel_q <= accel_d;
        end
    end

    // ------------------------------------------------------------
    // Pin sequencer
    // ------------------------------------------------------------
    flash_pins_s pins_q, pins_d;
    logic [7:0] cnt_q, cnt_d;
    op_e op_n;
    localparam flash_pins_s PINS_IDLE = '{address: 22'h000000, data_out: 8'h00,
        data_oe: 1'b0, cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, reset_n: 1'b1,
        reset_hv: 1'b0, a9_hv: 1'b0};

    always_comb begin
        pins_d = pins_q;
        cnt_d = cnt_q;
        st_d = st_q;
        rd_byte_d = rd_byte_q;
        op_n = op_e'(op_d);
        case (st_q)
            ST_IDLE: begin
                if (start_op) begin
                    pins_d.address = pin_addr(op_n, addr_q);
                    if (op_n == OP_HW_RESET) begin
                        pins_d.reset_n = 1'b0; // RULE_24
                        cnt_d = RP_CYC - 8'h01;
                        st_d = ST_RESET;
                    end else begin
                        pins_d.cs_n = 1'b0;
                        pins_d.reset_hv = (op_n == OP_PROTECT) || (op_n == OP_UNPROTECT); // RULE_27
                        pins_d.a9_hv = (op_n == OP_LOCK_VERIFY) || (op_n == OP_ID_READ); // RULE_27
                        pins_d.data_oe = is_write_op(op_n);
                        // Reset command restores array reads after a fail or id mode
                        pins_d.data_out = (op_n == OP_RESET_CMD) ? `FH_CMD_RESET : wdat_q; // RULE_18
                        cnt_d = SETUP_CYC - 8'h01;
                        st_d = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (is_write_op(op_e'(op_q))) begin
                    pins_d.we_n = 1'b0; // RULE_08
                    cnt_d = (pins_q.reset_hv ? PROT_CYC : WP_CYC) - 8'h01;
                    st_d = ST_ACTIVE;
                end else begin
                    pins_d.oe_n = 1'b0;
                    cnt_d = ACC_CYC - 8'h01;
                    st_d = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    // Data and address stay put past the strobe release
                    if (!pins_q.oe_n) rd_byte_d = data_bus_in;
                    pins_d.we_n = 1'b1;
                    pins_d.oe_n = 1'b1;
                    cnt_d = REC_CYC - 8'h01;
                    st_d = ST_RECOVER;
                end
            end
            ST_RESET: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    pins_d.reset_n = 1'b1;
                    cnt_d = REC_CYC - 8'h01;
                    st_d = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    pins_d = PINS_IDLE;
                    pins_d.address = pins_q.address;
                    st_d = ST_IDLE;
                end
            end
            default: begin
                pins_d = PINS_IDLE;
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_q <= PINS_IDLE;
            cnt_q <= 8'h00;
            st_q <= ST_IDLE;
            rd_byte_q <= 8'h00;
        end else begin
            pins_q <= pins_d;
            cnt_q <= cnt_d;
            st_q <= st_d;
            rd_byte_q <= rd_byte_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign address_bus = pins_q.address;
    assign data_bus_out = pins_q.data_out;
    assign data_bus_oe = pins_q.data_oe;
    assign chip_sel_n = pins_q.cs_n;
    assign write_strobe_n = pins_q.we_n;
    assign output_strobe_n = pins_q.oe_n;
    assign hard_reset_n = pins_q.reset_n;
    assign hard_reset_hv = pins_q.reset_hv;
    assign a9_hv = pins_q.a9_hv;
    assign accel_program_input = accel_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_cmd_strobe;
        !write_strobe_n |-> !chip_sel_n && output_strobe_n && data_bus_oe;
    endproperty
    a_cmd_strobe: assert property (p_cmd_strobe) else $error("bad write strobe pattern"); // RULE_08

    property p_data_at_release;
        $rose(write_strobe_n) |-> data_bus_oe && !chip_sel_n && $stable(data_bus_out);
    endproperty
    a_data_at_release: assert property (p_data_at_release) else $error("data lost at WE rise"); // RULE_10

    property p_addr_stable;
        !chip_sel_n && $past(!chip_sel_n) |-> $stable(address_bus);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in cycle"); // RULE_09

    property p_no_contention;
        !output_strobe_n |-> !data_bus_oe && write_strobe_n;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("host drives during read"); // RULE_07

    property p_protect_pattern;
        !write_strobe_n && hard_reset_hv |-> address_bus[1] && !address_bus[0] && hard_reset_n;
    endproperty
    a_protect_pattern: assert property (p_protect_pattern) else $error("bad protect pattern"); // RULE_04

    property p_hv_qualifier;
        (hard_reset_hv |-> hard_reset_n) and (a9_hv |-> !chip_sel_n || write_strobe_n);
    endproperty
    a_hv_qualifier: assert property (p_hv_qualifier) else $error("hv with pin low"); // RULE_27

    property p_reset_pulse;
        $fell(hard_reset_n) |-> !hard_reset_n [*2] ##[1:300] hard_reset_n;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse wrong"); // RULE_24

    property p_reset_cmd;
        start_op && op_n == OP_RESET_CMD |=> data_bus_out == `FH_CMD_RESET && data_bus_oe;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset command byte wrong"); // RULE_26

    property p_start_to_strobe;
        start_op && op_n != OP_HW_RESET |=> ##[1:300] (!write_strobe_n || !output_strobe_n);
    endproperty
    a_start_to_strobe: assert property (p_start_to_strobe) else $error("strobe never came"); // RULE_06

    property p_bvalid_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped");

    c_read: cover property (!output_strobe_n ##1 output_strobe_n);
    c_write: cover property (!write_strobe_n ##1 write_strobe_n);
    c_protect: cover property (hard_reset_hv && !write_strobe_n);
    c_hw_reset: cover property ($rose(hard_reset_n));

endmodule

// ---- test/flash_dev_model.sv ----
// Purpose: Behavioural parallel flash seen from its pins
// Assumes: One command cycle at a time
// Notes: Only read, program, reset, protect, unprotect, lock check and id read are modelled
`timescale 1ns/1ps
module flash_dev_model #(
    parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEV_ID = 8'h3c, // Arbitrary value
    parameter int BUSY_NS = 500
) (
    input wire logic [21:0] address_bus,
    input wire logic [7:0] data_bus_out,
    input wire logic data_bus_oe,
    output logic [7:0] data_bus_in,
    input wire logic chip_sel_n,
    input wire logic write_strobe_n,
    input wire logic output_strobe_n,
    input wire logic hard_reset_n,
    input wire logic hard_reset_hv,
    input wire logic a9_hv,
    input wire logic accel_program_input,
    output logic ready_busy_n
);
    localparam logic [7:0] UNLK [3] = '{8'haa, 8'h55, 8'ha0};
    logic [7:0] mem [logic [21:0]];
    logic [17:0] prot = '0;
    logic [21:0] la = '0;
    logic [1:0] st = 2'd0;
    logic [7:0] last = 8'h00;
    logic rd_en;
    function automatic int grp(input logic [5:0] s);
        return (s == 0) ? 0 : (s < 4) ? 1 : (s < 60) ? s / 4 + 1 : (s < 63) ? 16 : 17;
    endfunction
    function automatic logic [7:0] val(input logic [21:0] ad);
        if (a9_hv) return ad[1] ? {7'h00, prot[grp(ad[21:16])]} : (ad[0] ? DEV_ID : MFR_ID);
        return mem.exists(ad) ? mem[ad] : 8'hff;
    endfunction
    // Released bus shows the inverse of the last byte
    assign rd_en = hard_reset_n & ~chip_sel_n & ~output_strobe_n & write_strobe_n;
    assign data_bus_in = rd_en ? val(address_bus) : ~last;
    initial ready_busy_n = 1'b1;
    always @(negedge rd_en) last = val(address_bus);
    always @(negedge write_strobe_n or negedge chip_sel_n) begin
        if (!write_strobe_n && !chip_sel_n) la = address_bus;
    end
    always @(posedge write_strobe_n or posedge chip_sel_n) begin
        if ((write_strobe_n ^ chip_sel_n) && output_strobe_n && hard_reset_n) cmd(data_bus_out);
    end
    always @(negedge hard_reset_n) st = 2'd0;
    // Level sensitive so the pulse edges cannot race the high-voltage qualifier
    always @* begin
        if (hard_reset_hv && !chip_sel_n && !write_strobe_n && output_strobe_n
            && address_bus[1] && !address_bus[0]) begin
            if (address_bus[6]) prot = '0;
            else prot[grp(address_bus[21:16])] = 1'b1;
        end
    end
    task automatic cmd(input logic [7:0] dt);
        if (dt == 8'hf0 && ready_busy_n) st = 2'd0;
        else begin
            case (st)
                2'd0, 2'd1, 2'd2: st = (dt == UNLK[st]) ? st + 2'd1 : 2'd0;
                default: begin
                    if (!prot[grp(la[21:16])] || accel_program_input) mem[la] = val(la) & dt;
                    st = 2'd0;
                    ready_busy_n = 1'b0;
                    fork
                        #BUSY_NS ready_busy_n = 1'b1;
                    join_none
                end
            endcase
        end
    endtask
endmodule

// ---- test/tb.sv ----
// Purpose: Self-checking bench of the flash host controller
// Assumes: Short pin timings
// Notes: One AXI4-Lite transfer at a time
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module tb;
    import flash_host_pkg::*;
    localparam logic [7:0] MFR = 8'h5a; // Arbitrary value
    localparam logic [7:0] DEV = 8'h3c; // Arbitrary value
    localparam logic [7:0] SEQ [3] = '{8'haa, 8'h55, 8'ha0};
    localparam logic [21:0] CORNER [5] = '{22'h0, 22'h03ffff, 22'h040000, 22'h3c0000, 22'h3f0000};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, v;
    logic [21:0] address_bus, a;
    logic [7:0] data_bus_out, data_bus_in, d;
    logic data_bus_oe, chip_sel_n, write_strobe_n, output_strobe_n, hard_reset_n, hard_reset_hv;
    logic a9_hv, accel_program_input, ready_busy_n;
    logic acc_q = 1'b0;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    flash_host_ctrl #(.SETUP_CYC(8'h01), .ACC_CYC(8'h02), .WP_CYC(8'h02), .PROT_CYC(8'h03),
        .REC_CYC(8'h01), .RP_CYC(8'h03)) u_flash_host_ctrl (.*);
    flash_dev_model #(.MFR_ID(MFR), .DEV_ID(DEV)) u_flash_dev_model (.*);
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            $display("[ERR] %0t timeout", $time);
            results();
        end
    end
    // ----------------------------------------
    // Bus and flash tasks
    // ----------------------------------------
    function automatic logic [4:0] grp(input logic [5:0] s);
        return (s == 0) ? 5'd0 : (s < 4) ? 5'd1 : (s < 60) ? 5'(s / 4 + 1)
            : (s < 63) ? 5'd16 : 5'd17;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        logic aw, w, b;
        @(posedge clk);
        s_axi_awaddr <= ad;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= dt;
        s_axi_wstrb <= 4'($urandom);
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge clk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid & s_axi_bready;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] ad);
        logic ar, r;
        @(posedge clk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r = 1'b0;
        while (!r) begin
            @(negedge clk);
            ar = s_axi_arvalid & s_axi_arready;
            r = s_axi_rvalid & s_axi_rready;
            v = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) s_axi_rready <= 1'b0;
        end
    endtask
    task automatic fop(input op_e op, input logic [21:0] ad, input logic [7:0] dt);
        wr(`FH_OFS_ADDR, {10'h0, ad});
        wr(`FH_OFS_WDATA, {24'h0, dt});
        wr(`FH_OFS_CTRL, {23'h0, acc_q, 3'h0, 1'b1, 1'b0, op});
        v = 32'h1;
        while (v[`FH_ST_BUSY_BIT] !== 1'b0) rd(`FH_OFS_STATUS);
    endtask
    task automatic chkb(input op_e op, input logic [21:0] ad, input logic [7:0] exp);
        fop(op, ad, 8'h00);
        rd(`FH_OFS_RDATA);
        chk(v, {24'h0, exp});
    endtask
    task automatic unlock(input int n);
        for (int i = 0; i < n; i++) fop(OP_WRITE, 22'h0, SEQ[i]);
    endtask
    task automatic prog(input logic [21:0] ad, input logic [7:0] dt);
        unlock(3);
        fop(OP_WRITE, ad, dt);
        rd(`FH_OFS_STATUS);
        chk(v[`FH_ST_RDY_BIT], 1'b0);
        while (v[`FH_ST_RDY_BIT] !== 1'b1) rd(`FH_OFS_STATUS);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h31bf5b86));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        rd(`FH_OFS_STATUS);
        chk(v[`FH_ST_RDY_BIT], 1'b1);
        rd(8'h40);
        chk({v, rsp}, {32'h0, 2'b10});
        $display("test reset and map done");
        for (int i = 0; i < 20; i++) begin
            a = (i < 5) ? CORNER[i] : 22'($urandom);
            wr(`FH_OFS_ADDR, {10'h0, a});
            rd(`FH_OFS_STATUS);
            chk(v[13:8], a[21:16]);
            chk(v[20:16], grp(a[21:16]));
        end
        $display("test sector map done");
        for (int i = 0; i < 6; i++) begin
            a = {6'(i + 1), 16'($urandom)};
            d = 8'($urandom);
            prog(a, d);
            chkb(OP_READ, a, d);
        end
        $display("test program done");
        for (int i = 0; i < 2; i++) begin
            a = {6'(i + 10), 16'($urandom)};
            unlock(2);
            fop((i != 0) ? OP_HW_RESET : OP_RESET_CMD, 22'h0, 8'h00);
            fop(OP_WRITE, 22'h0, 8'ha0);
            fop(OP_WRITE, a, 8'h00);
            chkb(OP_READ, a, 8'hff);
        end
        $display("test aborted sequences done");
        a = {6'd40, 16'($urandom)};
        fop(OP_PROTECT, a, 8'h00);
        chkb(OP_LOCK_VERIFY, a, 8'h01);
        chkb(OP_LOCK_VERIFY, {6'd36, 16'h0}, 8'h00);
        prog(a, 8'h00);
        chkb(OP_READ, a, 8'hff);
        acc_q = 1'b1;
        prog({6'd41, a[15:0]}, 8'h3c);
        chk(accel_program_input, 1'b1);
        chkb(OP_READ, {6'd41, a[15:0]}, 8'h3c);
        acc_q = 1'b0;
        prog({6'd42, a[15:0]}, 8'h00);
        chkb(OP_READ, {6'd42, a[15:0]}, 8'hff);
        fop(OP_UNPROTECT, a, 8'h00);
        chkb(OP_LOCK_VERIFY, a, 8'h00);
        $display("test protection done");
        chkb(OP_ID_READ, 22'h0, MFR);
        chkb(OP_ID_READ, 22'h1, DEV);
        $display("test id done");
        results();
    end
endmodule
